// ===== logic/ptt_timebase.sv
// Periodic timebase tick generator with AXI4-Lite register slave
`timescale 1ns/1ps

module ptt_timebase #(
    parameter int CNT_W = 22,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Low-power mode and configuration options
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic oscillator_keep_in_stop,
    input wire logic extra_div128_select,
    // AXI4-Lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq
);

    // ==============================================================
    // Elaboration checks
    // ==============================================================
    if (CNT_W < ptt_pkg::CNT_W_MIN) begin : g_cnt_chk
        $error("CNT_W too small for the longest tap");
    end
    if (ADDR_W < 4) begin : g_addr_chk
        $error("ADDR_W too small for the register map");
    end

    // ==============================================================
    // Functions
    // ==============================================================
    // Address decode shared by the read and write paths
    function automatic ptt_pkg::ptt_sel_type decode(input logic [ADDR_W-1:0] addr);
        logic [7:0] a;
        a = 8'(addr);
        if (ADDR_W > 8 && (addr >> 8) != '0) begin
            decode = ptt_pkg::SEL_NONE;
        end else if (a == ptt_pkg::CTRL_OFF) begin
            decode = ptt_pkg::SEL_CTRL;
        end else if (a == ptt_pkg::STAT_OFF) begin
            decode = ptt_pkg::SEL_STAT;
        end else if (a == ptt_pkg::MASK_OFF) begin
            decode = ptt_pkg::SEL_MASK;
        end else begin
            decode = ptt_pkg::SEL_NONE;
        end
    endfunction

    // Counter bit watched for the tick, per tap code and prescale option
    function automatic logic [4:0] tap_bit(input logic [2:0] sel, input logic div128);
        logic [4:0] b;
        b = ptt_pkg::TAP_BIT_0;
        unique case (sel)
            3'h0: b = ptt_pkg::TAP_BIT_0;
            3'h1: b = ptt_pkg::TAP_BIT_1;
            3'h2: b = ptt_pkg::TAP_BIT_2;
            3'h3: b = ptt_pkg::TAP_BIT_3;
            3'h4: b = ptt_pkg::TAP_BIT_4;
            3'h5: b = ptt_pkg::TAP_BIT_5;
            3'h6: b = ptt_pkg::TAP_BIT_6;
            3'h7: b = ptt_pkg::TAP_BIT_7;
        endcase
        tap_bit = div128 ? 5'(b + ptt_pkg::DIV128_SHIFT) : b;
    endfunction

    // ==============================================================
    // State
    // ==============================================================
    logic aw_have_reg, aw_have_next;
    logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
    logic w_have_reg, w_have_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    ptt_pkg::ptt_ctrl_type ctrl_reg, ctrl_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic flag_reg, flag_next;
    logic [31:0] stat_reg, stat_next;
    logic [31:0] mask_reg, mask_next;
    logic irq_reg, irq_next;

    // Write strobes decoded from the bus, address selects and tick logic
    logic do_wr;
    logic ctrl_wr;
    logic ack_wr;
    logic stat_wr;
    logic mask_wr;
    logic ctrl_open;
    logic running;
    logic tick;
    logic [4:0] tbit;
    ptt_pkg::ptt_sel_type wsel;
    ptt_pkg::ptt_sel_type rsel;

    // ==============================================================
    // Bus write path
    // ==============================================================
    // Control register hides from the CPU in wait and stop mode
    assign ctrl_open = !wait_mode && !stop_mode;
    assign do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
    assign wsel = decode(aw_addr_reg);
    assign ctrl_wr = do_wr && wsel == ptt_pkg::SEL_CTRL && w_strb_reg[0] && ctrl_open;
    assign ack_wr = ctrl_wr && w_data_reg[ptt_pkg::ACK_BIT];
    assign stat_wr = do_wr && wsel == ptt_pkg::SEL_STAT && w_strb_reg[0];
    assign mask_wr = do_wr && wsel == ptt_pkg::SEL_MASK && w_strb_reg[0];

    // Address and data are caught independently, in either order
    always_comb begin
        aw_have_next = aw_have_reg;
        aw_addr_next = aw_addr_reg;
        w_have_next = w_have_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_have_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (do_wr) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = (wsel == ptt_pkg::SEL_NONE) ? ptt_pkg::RESP_SLVERR : ptt_pkg::RESP_OKAY;
        end
        awready_next = !aw_have_next;
        wready_next = !w_have_next;
    end

    // ==============================================================
    // Bus read path
    // ==============================================================
    assign rsel = decode(s_axi_araddr);

    // Acknowledge is write-only, so its bit position always reads zero
    always_comb begin
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = ptt_pkg::RESP_OKAY;
            rdata_next = ptt_pkg::WORD_ZERO;
            unique case (rsel)
                ptt_pkg::SEL_CTRL: begin
                    if (ctrl_open) begin
                        rdata_next[ptt_pkg::FLAG_BIT] = flag_reg;
                        rdata_next[ptt_pkg::TAP_MSB:ptt_pkg::TAP_LSB] = ctrl_reg.tap;
                        rdata_next[ptt_pkg::TIE_BIT] = ctrl_reg.tie;
                        rdata_next[ptt_pkg::EN_BIT] = ctrl_reg.en;
                    end
                end
                ptt_pkg::SEL_STAT: rdata_next = stat_reg;
                ptt_pkg::SEL_MASK: rdata_next = mask_reg;
                ptt_pkg::SEL_NONE: rresp_next = ptt_pkg::RESP_SLVERR;
            endcase
        end
        arready_next = !rvalid_next;
    end

    // ==============================================================
    // Control, counter and tick flag
    // ==============================================================
    // Clock is gated off in stop unless the oscillator is kept alive
    assign running = ctrl_reg.en && !(stop_mode && !oscillator_keep_in_stop);
    assign tbit = tap_bit(ctrl_reg.tap, extra_div128_select);

    always_comb begin
        ctrl_next = ctrl_reg;
        if (ctrl_wr) begin
            // Tap is stored as written; changing it while enabled may glitch one tick
            ctrl_next.tap = w_data_reg[ptt_pkg::TAP_MSB:ptt_pkg::TAP_LSB];
            ctrl_next.tie = w_data_reg[ptt_pkg::TIE_BIT];
            ctrl_next.en = w_data_reg[ptt_pkg::EN_BIT];
        end
        cnt_next = cnt_reg;
        if (!ctrl_reg.en) begin
            cnt_next = '0;
        end else if (running) begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    // Tick on the rising edge of the tap: half a period first, full periods after
    assign tick = running && !cnt_reg[tbit] && cnt_next[tbit];

    // Flags: a tick in the same cycle as a clear wins
    always_comb begin
        flag_next = flag_reg;
        if (ack_wr) begin
            flag_next = 1'b0;
        end
        if (tick) begin
            flag_next = 1'b1;
        end
        stat_next = stat_reg;
        if (stat_wr) begin
            stat_next = stat_reg & ~(w_data_reg & ptt_pkg::STAT_MASK_BITS);
        end
        if (tick) begin
            stat_next[ptt_pkg::STAT_TICK_BIT] = 1'b1;
        end
        mask_next = mask_reg;
        if (mask_wr) begin
            mask_next = w_data_reg & ptt_pkg::STAT_MASK_BITS;
        end
        // Level interrupt, also the periodic wakeup from stop
        irq_next = (flag_next && ctrl_next.tie) || ((stat_next & mask_next) != ptt_pkg::WORD_ZERO);
    end

    // ==============================================================
    // Registers
    // ==============================================================
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_have_reg <= 1'b0;
            w_data_reg <= ptt_pkg::WORD_ZERO;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= ptt_pkg::RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= ptt_pkg::RESP_OKAY;
            rdata_reg <= ptt_pkg::WORD_ZERO;
            ctrl_reg <= ptt_pkg::CTRL_RST;
            cnt_reg <= '0;
            flag_reg <= 1'b0;
            stat_reg <= ptt_pkg::WORD_ZERO;
            mask_reg <= ptt_pkg::WORD_ZERO;
            irq_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            aw_addr_reg <= aw_addr_next;
            w_have_reg <= w_have_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            cnt_reg <= cnt_next;
            flag_reg <= flag_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

    // ==============================================================
    // Outputs
    // ==============================================================
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign irq = irq_reg;

endmodule

// ===== logic/ptt_pkg.sv
// Package with register map, field layout and tap table of the periodic timebase tick block
package ptt_pkg;

    // ==============================================================
    // Register map (byte addresses, one aligned word each)
    // ==============================================================
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] MASK_OFF = 8'h08;

    // ==============================================================
    // Control and status register field positions
    // ==============================================================
    localparam int EN_BIT = 1;
    localparam int TIE_BIT = 2;
    localparam int ACK_BIT = 3;
    localparam int TAP_LSB = 4;
    localparam int TAP_MSB = 6;
    localparam int FLAG_BIT = 7;
    localparam int STAT_TICK_BIT = 0;
    localparam logic [31:0] STAT_MASK_BITS = 32'h0000_0001;

    // ==============================================================
    // Reset values
    // ==============================================================
    localparam logic [2:0] TAP_RST = 3'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ==============================================================
    // Divider chain taps: counter bit whose rising edge marks a tick
    // ==============================================================
    // Codes 0..7 give dividers 32768, 8192, 2048, 128, 64, 32, 16, 8
    localparam logic [4:0] TAP_BIT_0 = 5'h0E;
    localparam logic [4:0] TAP_BIT_1 = 5'h0C;
    localparam logic [4:0] TAP_BIT_2 = 5'h0A;
    localparam logic [4:0] TAP_BIT_3 = 5'h06;
    localparam logic [4:0] TAP_BIT_4 = 5'h05;
    localparam logic [4:0] TAP_BIT_5 = 5'h04;
    localparam logic [4:0] TAP_BIT_6 = 5'h03;
    localparam logic [4:0] TAP_BIT_7 = 5'h02;
    // Extra divide-by-128 moves every tap up by seven stages
    localparam logic [4:0] DIV128_SHIFT = 5'h07;
    localparam int CNT_W_MIN = 22;

    // ==============================================================
    // AXI4-Lite responses
    // ==============================================================
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==============================================================
    // Types
    // ==============================================================
    typedef enum logic [1:0] {
        SEL_CTRL = 2'b00,
        SEL_STAT = 2'b01,
        SEL_MASK = 2'b10,
        SEL_NONE = 2'b11
    } ptt_sel_type;

    typedef struct packed {
        logic [2:0] tap;
        logic tie;
        logic en;
    } ptt_ctrl_type;

    localparam ptt_ctrl_type CTRL_RST = '{tap: TAP_RST, tie: 1'b0, en: 1'b0};

endpackage

// ===== tb/ptt_timebase_asserts.sv
// Checker of bus answers and interrupt behaviour at the timebase block ports
`timescale 1ns/1ps

module ptt_timebase_asserts #(
    parameter int CNT_W = 22,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Write channels
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    input wire logic irq
);
    // ==============================================================
    // Helpers
    // ==============================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Only three word offsets are decoded
    wire logic aw_bad = !(s_axi_awaddr inside {ptt_pkg::CTRL_OFF, ptt_pkg::STAT_OFF, ptt_pkg::MASK_OFF});
    wire logic ar_bad = !(s_axi_araddr inside {ptt_pkg::CTRL_OFF, ptt_pkg::STAT_OFF, ptt_pkg::MASK_OFF});
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence bad_take;
        wr_take ##0 aw_bad;
    endsequence

    // ==============================================================
    // Properties
    // ==============================================================
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    wr_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    wr_error_a: assert property (bad_take |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == ptt_pkg::RESP_SLVERR))
        else $error("unmapped write not refused");
    rd_error_a: assert property (s_axi_arvalid && s_axi_arready && ar_bad
        |=> s_axi_rresp == ptt_pkg::RESP_SLVERR && s_axi_rdata == ptt_pkg::WORD_ZERO)
        else $error("unmapped read not refused");
    ack_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_rdata[3])
        else $error("acknowledge or upper bits read nonzero");
    irq_hold_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
        else $error("interrupt dropped without a clearing write");
endmodule

bind ptt_timebase ptt_timebase_asserts #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) chk_u (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq));

// ===== tb/ptt_timebase_test.sv
// Self-checking testbench of the periodic timebase tick block
`timescale 1ns/1ps

module ptt_timebase_test;
    // ==============================================================
    // Stimulus and observed signals
    // ==============================================================
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wait_mode = 1'b0, stop_mode = 1'b0, osc_keep = 1'b0, div128 = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_total = 0, compares = 0, cyc = 0, last_b = 0;
    int div_tab [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

    ptt_timebase dut_u (.clk(clk), .sys_rst(sys_rst), .wait_mode(wait_mode), .stop_mode(stop_mode),
        .oscillator_keep_in_stop(osc_keep), .extra_div128_select(div128),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

    // 10 MHz clock and a cycle count that also bounds the run
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 90000) begin
            err_total++;
            $display("[FAIL] %0t ns: run timed out", $time);
            test_done();
        end
    end

    // ==============================================================
    // Compare, bus and wait tasks
    // ==============================================================
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t ns: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_cycles(input int got, input int exp);
        compares++;
        if (got != exp) begin
            err_total++;
            $display("[FAIL] %0t ns: interval %0d expected %0d", $time, got, exp);
        end
    endtask
    // Address and data offered together; each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw = 1, w = 1, b = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b) begin
            @(posedge clk);
            if (!aw && !w && bvalid === 1'b1) begin
                b = 1;
                r = bresp;
                last_b = cyc;
            end
            if (aw && awready === 1'b1) begin
                aw = 0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 0;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar = 1, got = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got) begin
            @(posedge clk);
            if (!ar && rvalid === 1'b1) begin
                got = 1;
                d = rdata;
                r = rresp;
            end
            if (ar && arready === 1'b1) begin
                ar = 0;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask
    task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        cmp_word(d, exp);
    endtask
    // Returns the cycle at which irq was first seen high, or -1
    task automatic wait_irq(input int lim, output int t);
        t = -1;
        for (int n = 0; n < lim && t < 0; n++) begin
            @(posedge clk);
            if (irq === 1'b1) t = cyc;
        end
    endtask

    // ==============================================================
    // Scenarios
    // ==============================================================
    task automatic t_reset_map();
        logic [31:0] d;
        logic [1:0] r;
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h00000000);
        rd_cmp(ptt_pkg::STAT_OFF, 32'h00000000);
        rd_cmp(ptt_pkg::MASK_OFF, 32'h00000000);
        axi_rd(8'h0C, d, r);
        cmp_word({d[31:2], r}, {30'h0, ptt_pkg::RESP_SLVERR});
        axi_wr(8'h0C, 32'h000000FF, r);
        cmp_word({30'h0, r}, {30'h0, ptt_pkg::RESP_SLVERR});
    endtask
    // Restart from disabled, then time the first and the next tick
    task automatic t_rate(input int code, input logic sel);
        int dv, t1, t2;
        dv = div_tab[code] << (sel ? 7 : 0);
        wr(ptt_pkg::CTRL_OFF, 32'h00000008);
        // Prescale switched only while disabled, else a stray tick can outlive the acknowledge
        div128 <= sel;
        wr(ptt_pkg::CTRL_OFF, 32'h00000006 | (code << 4));
        wait_irq(dv + 20, t1);
        cmp_cycles(t1 - last_b, dv / 2);
        wr(ptt_pkg::CTRL_OFF, 32'h0000000E | (code << 4));
        wait_irq(dv + 20, t2);
        cmp_cycles(t2 - t1, dv);
    endtask
    task automatic t_flag_hold();
        repeat (20) @(posedge clk);
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h000000F6);
        wr(ptt_pkg::CTRL_OFF, 32'h00000074);
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h000000F4);
        wr(ptt_pkg::CTRL_OFF, 32'h0000007C);
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h00000074);
        cmp_word({31'h0, irq}, 32'h00000000);
        wr(ptt_pkg::CTRL_OFF, 32'h00000072);
        repeat (20) @(posedge clk);
        cmp_word({31'h0, irq}, 32'h00000000);
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h000000F2);
        rd_cmp(ptt_pkg::STAT_OFF, 32'h00000001);
        wr(ptt_pkg::MASK_OFF, 32'h00000001);
        cmp_word({31'h0, irq}, 32'h00000001);
        wr(ptt_pkg::CTRL_OFF, 32'h00000008);
        wr(ptt_pkg::STAT_OFF, 32'h00000001);
        cmp_word({31'h0, irq}, 32'h00000000);
        rd_cmp(ptt_pkg::STAT_OFF, 32'h00000000);
        wr(ptt_pkg::MASK_OFF, 32'h00000000);
    endtask
    // Control register hidden in wait while the counter keeps ticking
    task automatic t_wait();
        int t;
        wr(ptt_pkg::CTRL_OFF, 32'h00000076);
        wait_mode <= 1'b1;
        wait_irq(20, t);
        cmp_word({31'h0, irq}, 32'h00000001);
        wr(ptt_pkg::CTRL_OFF, 32'h0000007E);
        cmp_word({31'h0, irq}, 32'h00000001);
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h00000000);
        wait_mode <= 1'b0;
        // Disabled before wait, the flag must stay clear however long the wait lasts
        wr(ptt_pkg::CTRL_OFF, 32'h0000007C);
        wait_mode <= 1'b1;
        repeat (40) @(posedge clk);
        cmp_word({31'h0, irq}, 32'h00000000);
        wait_mode <= 1'b0;
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h00000074);
    endtask
    // Freeze in stop, unless the oscillator is kept running there
    task automatic t_stop();
        int t;
        wr(ptt_pkg::CTRL_OFF, 32'h0000007C);
        wr(ptt_pkg::CTRL_OFF, 32'h00000076);
        stop_mode <= 1'b1;
        repeat (30) @(posedge clk);
        cmp_word({31'h0, irq}, 32'h00000000);
        rd_cmp(ptt_pkg::CTRL_OFF, 32'h00000000);
        osc_keep <= 1'b1;
        wait_irq(20, t);
        cmp_word({31'h0, irq}, 32'h00000001);
        stop_mode <= 1'b0;
        osc_keep <= 1'b0;
    endtask

    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Main sequence after three cycles of reset
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset_map();
        for (int c = 0; c < 8; c++) t_rate(c, 1'b0);
        t_rate(7, 1'b1);
        t_rate(7, 1'b0);
        t_flag_hold();
        t_wait();
        t_stop();
        test_done();
    end
endmodule
